// ---- hw/rotate_subtract_skip_alu.sv ----
// Rotate, subtract, increment/decrement-skip, bit-test, set and swap datapath.
// Assumes mem_rdata shows the byte at op_addr in the same cycle as op_valid,
// and that the decoder holds op_valid off while op_ready is low.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module rotate_subtract_skip_alu
  import alu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              op_valid,
  input  wire logic [4:0]        op_code,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [2:0]        op_bit,
  input  wire logic [7:0]        op_imm,
  input  wire logic [7:0]        mem_rdata,
  output logic                   op_ready,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_waddr,
  output logic [7:0]             mem_wdata,
  output logic                   skip_next,
  output logic [7:0]             accumulator,
  output logic                   carry_flag,
  output logic                   aux_carry_flag,
  output logic                   zero_flag,
  output logic                   overflow_flag,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  phase_e            phase_r;
  logic [7:0]        accum_r;
  logic              carry_r;
  logic              aux_r;
  logic              zero_r;
  logic              ovf_r;
  logic              mem_we_r;
  logic [ADDR_W-1:0] mem_waddr_r;
  logic [7:0]        mem_wdata_r;
  logic              skip_r;
  logic [31:0]       prdata_r;
  logic              op_fire;
  op_e               op;
  logic [7:0]        sub_b;
  logic              sub_cin;
  logic [8:0]        sum9;
  logic [4:0]        sum5;
  logic              sub_ovf;
  logic [7:0]        dec_val;
  logic [7:0]        inc_val;
  logic [7:0]        bit_mask;
  logic [7:0]        res_nxt;
  logic              wr_mem_nxt;
  logic              wr_accum_nxt;
  logic              upd_carry_nxt;
  logic              upd_arith_nxt;
  logic              carry_nxt;
  logic              skip_nxt;
  logic              apb_wr;
  logic              apb_rd;
  logic              apb_hit;

  assign op       = op_e'(op_code);
  assign op_ready = (phase_r == ST_EXEC);
  assign op_fire  = op_valid && op_ready;

  // ---------------------------------------------------------------
  // Subtractor, incrementer and bit mask
  // ---------------------------------------------------------------
  // Operand and carry-in select for all subtract forms
  assign sub_b   = (op == SUBTRACT_IMM) ? op_imm : mem_rdata;
  assign sub_cin = ((op == SUBTRACT_WITH_BORROW_ACC) || (op == SUBTRACT_WITH_BORROW_MEM))
                   ? carry_r : 1'b1;
  // Add the inverted operand; low nibble sum gives the bit 3 carry
  assign sum9    = {1'b0, accum_r} + {1'b0, ~sub_b} + {8'h00, sub_cin};
  assign sum5    = {1'b0, accum_r[NIB_MSB:0]} + {1'b0, ~sub_b[NIB_MSB:0]} + {4'h0, sub_cin};
  assign sub_ovf = (accum_r[MSB] ~^ ~sub_b[MSB]) & (accum_r[MSB] ^ sum9[MSB]);
  assign dec_val = mem_rdata - BYTE_ONE;
  assign inc_val = mem_rdata + BYTE_ONE;
  assign bit_mask = BYTE_ONE << op_bit;

  // ---------------------------------------------------------------
  // Operation decode: result, destination, flag and skip control
  // ---------------------------------------------------------------
  always_comb begin
    res_nxt       = mem_rdata;
    wr_mem_nxt    = 1'b0;
    wr_accum_nxt  = 1'b0;
    upd_carry_nxt = 1'b0;
    upd_arith_nxt = 1'b0;
    carry_nxt     = carry_r;
    skip_nxt      = 1'b0;
    case (op)
      ROTATE_LEFT_CARRY_MEM: begin
        res_nxt       = {mem_rdata[MSB-1:0], carry_r};
        carry_nxt     = mem_rdata[MSB];
        wr_mem_nxt    = 1'b1;
        upd_carry_nxt = 1'b1;
      end
      ROTATE_LEFT_CARRY_ACC: begin
        res_nxt       = {mem_rdata[MSB-1:0], carry_r};
        carry_nxt     = mem_rdata[MSB];
        wr_accum_nxt  = 1'b1;
        upd_carry_nxt = 1'b1;
      end
      ROTATE_RIGHT_MEM: begin
        res_nxt    = {mem_rdata[0], mem_rdata[MSB:1]};
        wr_mem_nxt = 1'b1;
      end
      ROTATE_RIGHT_ACC: begin
        res_nxt      = {mem_rdata[0], mem_rdata[MSB:1]};
        wr_accum_nxt = 1'b1;
      end
      ROTATE_RIGHT_CARRY_MEM: begin
        res_nxt       = {carry_r, mem_rdata[MSB:1]};
        carry_nxt     = mem_rdata[0];
        wr_mem_nxt    = 1'b1;
        upd_carry_nxt = 1'b1;
      end
      ROTATE_RIGHT_CARRY_ACC: begin
        res_nxt       = {carry_r, mem_rdata[MSB:1]};
        carry_nxt     = mem_rdata[0];
        wr_accum_nxt  = 1'b1;
        upd_carry_nxt = 1'b1;
      end
      SUBTRACT_WITH_BORROW_ACC, SUBTRACT_TO_ACC, SUBTRACT_IMM: begin
        res_nxt       = sum9[7:0];
        carry_nxt     = sum9[8];
        wr_accum_nxt  = 1'b1;
        upd_carry_nxt = 1'b1;
        upd_arith_nxt = 1'b1;
      end
      SUBTRACT_WITH_BORROW_MEM, SUBTRACT_TO_MEM: begin
        res_nxt       = sum9[7:0];
        carry_nxt     = sum9[8];
        wr_mem_nxt    = 1'b1;
        upd_carry_nxt = 1'b1;
        upd_arith_nxt = 1'b1;
      end
      DECREMENT_SKIP_ZERO_MEM: begin
        res_nxt    = dec_val;
        wr_mem_nxt = 1'b1;
        skip_nxt   = (dec_val == BYTE_ZERO);
      end
      DECREMENT_SKIP_ZERO_ACC: begin
        res_nxt      = dec_val;
        wr_accum_nxt = 1'b1;
        skip_nxt     = (dec_val == BYTE_ZERO);
      end
      INCREMENT_SKIP_ZERO_MEM: begin
        res_nxt    = inc_val;
        wr_mem_nxt = 1'b1;
        skip_nxt   = (inc_val == BYTE_ZERO);
      end
      INCREMENT_SKIP_ZERO_ACC: begin
        res_nxt      = inc_val;
        wr_accum_nxt = 1'b1;
        skip_nxt     = (inc_val == BYTE_ZERO);
      end
      SKIP_BIT_NONZERO: begin
        skip_nxt = |(mem_rdata & bit_mask);
      end
      SET_BYTE: begin
        res_nxt    = BYTE_ONES;
        wr_mem_nxt = 1'b1;
      end
      SET_BIT: begin
        res_nxt    = mem_rdata | bit_mask;
        wr_mem_nxt = 1'b1;
      end
      NIBBLE_EXCHANGE_MEM: begin
        res_nxt    = {mem_rdata[NIB_MSB:0], mem_rdata[MSB:NIB_MSB+1]};
        wr_mem_nxt = 1'b1;
      end
      NIBBLE_EXCHANGE_ACC: begin
        res_nxt      = {mem_rdata[NIB_MSB:0], mem_rdata[MSB:NIB_MSB+1]};
        wr_accum_nxt = 1'b1;
      end
      default: begin
        res_nxt = mem_rdata;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Execution phase: a skip adds one dummy cycle
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_r <= ST_EXEC;
    end else begin
      case (phase_r)
        ST_EXEC: begin
          if (op_fire && skip_nxt) begin
            phase_r <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          phase_r <= ST_EXEC;
        end
        default: begin
          phase_r <= ST_EXEC;
        end
      endcase
    end
  end

  // Skip pulse tells the fetch unit to drop its prefetched word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= op_fire && skip_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Data memory write port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_we_r    <= 1'b0;
      mem_waddr_r <= '0;
      mem_wdata_r <= BYTE_ZERO;
    end else begin
      mem_we_r <= op_fire && wr_mem_nxt;
      if (op_fire && wr_mem_nxt) begin
        mem_waddr_r <= op_addr;
        mem_wdata_r <= res_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register bus decode (no wait states)
  // ---------------------------------------------------------------
  assign apb_hit = (paddr == ADDR_ACCUM) || (paddr == ADDR_FLAGS) || (paddr == ADDR_STATUS);
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_hit;

  // Accumulator; a datapath write beats a bus write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      accum_r <= ACCUM_RST;
    end else if (op_fire && wr_accum_nxt) begin
      accum_r <= res_nxt;
    end else if (apb_wr && (paddr == ADDR_ACCUM)) begin
      accum_r <= pwdata[7:0];
    end
  end

  // Carry flag: datapath update wins over bus write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      carry_r <= 1'b0;
    end else if (op_fire && upd_carry_nxt) begin
      carry_r <= carry_nxt;
    end else if (apb_wr && (paddr == ADDR_FLAGS)) begin
      carry_r <= pwdata[POS_CARRY];
    end
  end

  // Auxiliary carry, zero and overflow follow only the subtract forms
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_r  <= 1'b0;
      zero_r <= 1'b0;
      ovf_r  <= 1'b0;
    end else if (op_fire && upd_arith_nxt) begin
      aux_r  <= sum5[4];
      zero_r <= (sum9[7:0] == BYTE_ZERO);
      ovf_r  <= sub_ovf;
    end else if (apb_wr && (paddr == ADDR_FLAGS)) begin
      aux_r  <= pwdata[POS_AUX];
      zero_r <= pwdata[POS_ZERO];
      ovf_r  <= pwdata[POS_OVF];
    end
  end

  // Read data latched in the setup cycle, stable through access
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata_r <= 32'h0000_0000;
      case (paddr)
        ADDR_ACCUM: prdata_r[7:0] <= accum_r;
        ADDR_FLAGS: begin
          prdata_r[POS_CARRY] <= carry_r;
          prdata_r[POS_AUX]   <= aux_r;
          prdata_r[POS_ZERO]  <= zero_r;
          prdata_r[POS_OVF]   <= ovf_r;
        end
        ADDR_STATUS: begin
          prdata_r[POS_DUMMY] <= (phase_r == ST_DUMMY);
          prdata_r[POS_SKIP]  <= skip_r;
        end
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign mem_we         = mem_we_r;
  assign mem_waddr      = mem_waddr_r;
  assign mem_wdata      = mem_wdata_r;
  assign skip_next      = skip_r;
  assign accumulator    = accum_r;
  assign carry_flag     = carry_r;
  assign aux_carry_flag = aux_r;
  assign zero_flag      = zero_r;
  assign overflow_flag  = ovf_r;
  assign prdata         = prdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_ROTL_CARRY_MEM: assert property (
    op_fire && op == ROTATE_LEFT_CARRY_MEM |=> mem_we &&
      mem_wdata == {$past(mem_rdata[6:0]), $past(carry_r)} && carry_flag == $past(mem_rdata[7]))
    else $error("left rotate to memory wrong");
  AST_ROTL_CARRY_ACCUM: assert property (
    op_fire && op == ROTATE_LEFT_CARRY_ACC |=> !mem_we &&
      accumulator == {$past(mem_rdata[6:0]), $past(carry_r)})
    else $error("left rotate to accumulator wrong");
  AST_ROTR_MEM: assert property (
    op_fire && op == ROTATE_RIGHT_MEM |=> mem_we && $stable(carry_flag) &&
      mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
    else $error("right rotate to memory wrong");
  AST_ROTR_CARRY_ACCUM: assert property (
    op_fire && op == ROTATE_RIGHT_CARRY_ACC |=> !mem_we &&
      accumulator == {$past(carry_r), $past(mem_rdata[7:1])} && carry_flag == $past(mem_rdata[0]))
    else $error("right rotate through carry wrong");
  AST_SUB_BORROW: assert property (
    op_fire && op == SUBTRACT_WITH_BORROW_ACC |=>
      {carry_flag, accumulator} == $past({1'b0, accum_r} + {1'b0, ~mem_rdata} + {8'h00, carry_r}))
    else $error("subtract with borrow wrong");
  AST_SUB_IMM: assert property (
    op_fire && op == SUBTRACT_IMM |=>
      accumulator == $past(accum_r - op_imm) && zero_flag == (accumulator == BYTE_ZERO))
    else $error("subtract immediate wrong");
  AST_DEC_SKIP: assert property (
    op_fire && op == DECREMENT_SKIP_ZERO_MEM && mem_rdata == BYTE_ONE |=>
      skip_next && mem_we && mem_wdata == BYTE_ZERO && !op_ready ##1 op_ready && !skip_next)
    else $error("decrement skip wrong");
  AST_INC_SKIP_ACCUM: assert property (
    op_fire && op == INCREMENT_SKIP_ZERO_ACC |=>
      accumulator == $past(inc_val) && skip_next == (accumulator == BYTE_ZERO) && !mem_we)
    else $error("increment skip wrong");
  AST_BIT_TEST: assert property (
    op_fire && op == SKIP_BIT_NONZERO |=> skip_next == $past(mem_rdata[op_bit]) && !mem_we)
    else $error("bit test skip wrong");
  AST_NO_SKIP_ONE_CYCLE: assert property (
    op_fire && !skip_nxt |=> op_ready && !skip_next)
    else $error("unskipped op took extra cycle");
  AST_SET_BIT: assert property (
    op_fire && op == SET_BIT |=> mem_we && mem_wdata == ($past(mem_rdata) | $past(bit_mask)))
    else $error("set bit wrong");
  AST_SWAP_MEM: assert property (
    op_fire && op == NIBBLE_EXCHANGE_MEM |=>
      mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && $stable(carry_flag))
    else $error("nibble swap wrong");

  COV_SKIP: cover property (op_fire && skip_nxt ##1 skip_next ##1 op_ready);
  COV_SUB_OVF: cover property (op_fire && op == SUBTRACT_TO_MEM ##1 overflow_flag);
  COV_BACK_TO_BACK: cover property (op_fire ##1 op_fire ##1 op_fire);

endmodule

`default_nettype wire

// ---- include/alu_pkg.sv ----
// Constants, opcodes and register map for the rotate, subtract and skip datapath.
// Assumes one core clock; the decoder presents one operation per cycle.
// Function
// - Left rotate through carry, result to memory
// - Left rotate through carry, result to accumulator
// - Plain right rotate to memory, flags kept
// - Plain right rotate to accumulator, flags kept
// - Right rotate through carry to memory
// - Right rotate through carry to accumulator
// - Subtract with borrow: A plus not m plus carry
// - Subtract memory: A plus not m plus one
// - Subtract immediate into accumulator, four flags
// - Decrement memory, skip when zero, no flags
// - Decrement into accumulator, skip when zero
// - Increment memory, skip when zero, no flags
// - Increment into accumulator, skip when zero
// - Skip when selected memory bit is one
// - Skip discards prefetch, adds one dummy cycle
// - Set byte writes all ones, no flags
// - Set bit forces one selected bit only
// - Nibble swap back to memory, no flags
// - Nibble swap into accumulator, memory kept
package alu_pkg;

  // ---------------------------------------------------------------
  // Operation codes presented by the instruction decoder
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_IDLE, ROTATE_LEFT_CARRY_MEM, ROTATE_LEFT_CARRY_ACC, ROTATE_RIGHT_MEM,
    ROTATE_RIGHT_ACC, ROTATE_RIGHT_CARRY_MEM, ROTATE_RIGHT_CARRY_ACC,
    SUBTRACT_WITH_BORROW_ACC, SUBTRACT_WITH_BORROW_MEM, SUBTRACT_TO_ACC,
    SUBTRACT_TO_MEM, SUBTRACT_IMM, DECREMENT_SKIP_ZERO_MEM, DECREMENT_SKIP_ZERO_ACC,
    INCREMENT_SKIP_ZERO_MEM, INCREMENT_SKIP_ZERO_ACC, SKIP_BIT_NONZERO,
    SET_BYTE, SET_BIT, NIBBLE_EXCHANGE_MEM, NIBBLE_EXCHANGE_ACC
  } op_e;

  typedef enum logic {ST_EXEC, ST_DUMMY} phase_e;

  // ---------------------------------------------------------------
  // Register map, byte addresses on the register bus
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_ACCUM  = 12'h000;
  localparam logic [11:0] ADDR_FLAGS  = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Flag register field positions
  localparam int POS_CARRY = 0;
  localparam int POS_AUX   = 1;
  localparam int POS_ZERO  = 2;
  localparam int POS_OVF   = 3;
  // Status register field positions
  localparam int POS_DUMMY = 0;
  localparam int POS_SKIP  = 1;

  // Data constants
  localparam logic [7:0] BYTE_ONES  = 8'hff;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [7:0] BYTE_ONE   = 8'h01;
  localparam logic [7:0] ACCUM_RST  = 8'h00;
  localparam int         MSB        = 7;
  localparam int         NIB_MSB    = 3;

endpackage

// ---- testbench/data_mem_model.sv ----
// Data memory model that sits on the far side of the datapath.
// Assumes one write strobe per cycle; the bench presets bytes by hierarchy.
`timescale 1ns/10ps
`default_nettype none

module data_mem_model #(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              op_valid,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_waddr,
  input  wire logic [7:0]        mem_wdata,
  output logic      [7:0]        mem_rdata
);
  // ------------------------------------------------------------
  // Storage and ports
  // ------------------------------------------------------------
  logic [7:0] mem [2**ADDR_W];
  logic       tog = 1'b0;

  // Real byte only while an operation is offered, junk otherwise
  assign mem_rdata = op_valid ? mem[op_addr] : {8{tog}};

  // Write lands on the edge that ends the strobe cycle
  always @(posedge ref_clk) begin
    tog <= ~tog;
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end
endmodule

`default_nettype wire

// ---- testbench/tb_rotate_subtract_skip_alu.sv ----
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes the package alu_pkg and the data memory model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_rotate_subtract_skip_alu
  import alu_pkg::*;
();
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic        ref_clk, rst_n, op_valid, op_ready, mem_we, skip_next;
  logic [4:0]  op_code;
  logic [7:0]  op_addr, op_imm, mem_rdata, mem_waddr, mem_wdata, accumulator;
  logic [2:0]  op_bit;
  logic        carry_flag, aux_carry_flag, zero_flag, overflow_flag;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  e_acc;
  logic        e_c, e_ac, e_z, e_ov;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  rotate_subtract_skip_alu uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_addr(op_addr), .op_bit(op_bit), .op_imm(op_imm), .mem_rdata(mem_rdata),
    .op_ready(op_ready), .mem_we(mem_we), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .skip_next(skip_next), .accumulator(accumulator),
    .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
    .zero_flag(zero_flag), .overflow_flag(overflow_flag), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  data_mem_model mem_m (
    .ref_clk(ref_clk), .op_valid(op_valid), .op_addr(op_addr), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Load accumulator and flags over the bus and track them
  task automatic set_state(input logic [7:0] a, input logic [3:0] f);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, ADDR_ACCUM, {24'h0, a}, rd, er);
    apb(1'b1, ADDR_FLAGS, {28'h0, f}, rd, er);
    apb(1'b0, ADDR_FLAGS, 32'h0, rd, er);
    chk(rd, {28'h0, f});
    e_acc = a;
    {e_ov, e_z, e_ac, e_c} = f;
  endtask

  // Issue one operation on byte m and judge every result
  task automatic run_op(input op_e o, input logic [7:0] m, input logic [7:0] imm,
                        input logic [2:0] b);
    logic [7:0] r, y;
    logic [8:0] s;
    logic [4:0] h;
    logic       cin, wa, wm, sk;
    r = m;
    y = ~m;
    cin = 1'b1;
    sk = 1'b0;
    case (o)
      ROTATE_LEFT_CARRY_MEM, ROTATE_LEFT_CARRY_ACC: begin
        r = {m[6:0], e_c};
        e_c = m[7];
      end
      ROTATE_RIGHT_MEM, ROTATE_RIGHT_ACC: r = {m[0], m[7:1]};
      ROTATE_RIGHT_CARRY_MEM, ROTATE_RIGHT_CARRY_ACC: begin
        r = {e_c, m[7:1]};
        e_c = m[0];
      end
      DECREMENT_SKIP_ZERO_MEM, DECREMENT_SKIP_ZERO_ACC: r = m - 8'h01;
      INCREMENT_SKIP_ZERO_MEM, INCREMENT_SKIP_ZERO_ACC: r = m + 8'h01;
      SKIP_BIT_NONZERO: sk = m[b];
      SET_BYTE: r = 8'hff;
      SET_BIT: r[b] = 1'b1;
      NIBBLE_EXCHANGE_MEM, NIBBLE_EXCHANGE_ACC: r = {m[3:0], m[7:4]};
      SUBTRACT_WITH_BORROW_ACC, SUBTRACT_WITH_BORROW_MEM, SUBTRACT_TO_ACC,
      SUBTRACT_TO_MEM, SUBTRACT_IMM: begin
        if (o == SUBTRACT_IMM) y = ~imm;
        if (o inside {SUBTRACT_WITH_BORROW_ACC, SUBTRACT_WITH_BORROW_MEM}) cin = e_c;
        s = {1'b0, e_acc} + {1'b0, y} + {8'h00, cin};
        h = {1'b0, e_acc[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        r = s[7:0];
        e_ov = (e_acc[7] == y[7]) && (r[7] != e_acc[7]);
        e_z = (r == 8'h00);
        e_ac = h[4];
        e_c = s[8];
      end
      default: ;
    endcase
    if (o inside {DECREMENT_SKIP_ZERO_MEM, DECREMENT_SKIP_ZERO_ACC,
                  INCREMENT_SKIP_ZERO_MEM, INCREMENT_SKIP_ZERO_ACC}) sk = (r == 8'h00);
    wa = o inside {ROTATE_LEFT_CARRY_ACC, ROTATE_RIGHT_ACC, ROTATE_RIGHT_CARRY_ACC,
                   SUBTRACT_WITH_BORROW_ACC, SUBTRACT_TO_ACC, SUBTRACT_IMM,
                   DECREMENT_SKIP_ZERO_ACC, INCREMENT_SKIP_ZERO_ACC, NIBBLE_EXCHANGE_ACC};
    wm = !wa && !(o inside {OP_IDLE, SKIP_BIT_NONZERO});
    if (wa) e_acc = r;
    mem_m.mem[8'h21] = m;
    op_valid <= 1'b1;
    op_code <= o;
    op_addr <= 8'h21;
    op_bit <= b;
    op_imm <= imm;
    @(posedge ref_clk);
    while (op_ready !== 1'b1) @(posedge ref_clk);
    op_valid <= sk;
    op_code <= SET_BYTE;
    #1;
    chk(mem_we, wm);
    if (wm) chk({mem_waddr, mem_wdata}, {8'h21, r});
    chk({skip_next, op_ready}, {sk, !sk});
    chk(accumulator, e_acc);
    chk({overflow_flag, zero_flag, aux_carry_flag, carry_flag}, {e_ov, e_z, e_ac, e_c});
    @(posedge ref_clk);
    op_valid <= 1'b0;
    if (sk) begin
      #1;
      chk({mem_we, skip_next, op_ready}, 32'h1);
    end
    // Let the write land before the next preset of the byte
    @(posedge ref_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({op_ready, mem_we, skip_next, pready, pslverr}, 32'h12);
    chk({accumulator, overflow_flag, zero_flag, aux_carry_flag, carry_flag}, 32'h0);
  endtask

  task automatic t_apb();
    logic [31:0] rd;
    logic        er;
    set_state(8'ha5, 4'h9);
    apb(1'b1, ADDR_STATUS, 32'h3, rd, er);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk({er, rd}, 33'h0);
    apb(1'b1, 12'h00c, 32'h77, rd, er);
    chk({er, rd}, 33'h1_0000_0000);
    set_state(8'h3c, 4'h0);
    apb(1'b0, ADDR_ACCUM, 32'h0, rd, er);
    chk(rd, 32'h3c);
  endtask

  task automatic t_rotate();
    op_e ro [6] = '{ROTATE_LEFT_CARRY_MEM, ROTATE_LEFT_CARRY_ACC, ROTATE_RIGHT_MEM,
                    ROTATE_RIGHT_ACC, ROTATE_RIGHT_CARRY_MEM, ROTATE_RIGHT_CARRY_ACC};
    set_state(8'h5a, 4'he);
    foreach (ro[i]) begin
      run_op(ro[i], 8'h81, 8'h00, 3'h0);
      run_op(ro[i], 8'h42, 8'h00, 3'h0);
    end
  endtask

  task automatic t_sub();
    op_e        so [5] = '{SUBTRACT_WITH_BORROW_ACC, SUBTRACT_WITH_BORROW_MEM,
                           SUBTRACT_TO_ACC, SUBTRACT_TO_MEM, SUBTRACT_IMM};
    logic [7:0] av [5] = '{8'h00, 8'h80, 8'h10, 8'h55, 8'h7f};
    logic [7:0] mv [5] = '{8'h01, 8'h01, 8'h01, 8'h55, 8'hff};
    foreach (so[i]) begin
      foreach (av[j]) begin
        set_state(av[j], {3'h0, j[0]});
        run_op(so[i], mv[j], mv[j], 3'h0);
      end
    end
  endtask

  task automatic t_skip();
    op_e        ko [4] = '{DECREMENT_SKIP_ZERO_MEM, DECREMENT_SKIP_ZERO_ACC,
                           INCREMENT_SKIP_ZERO_MEM, INCREMENT_SKIP_ZERO_ACC};
    logic [7:0] mv [5] = '{8'h01, 8'h02, 8'h00, 8'hff, 8'h80};
    set_state(8'h66, 4'ha);
    foreach (ko[i]) begin
      foreach (mv[j]) run_op(ko[i], mv[j], 8'h00, 3'h0);
    end
    for (int i = 0; i < 8; i++) begin
      run_op(SKIP_BIT_NONZERO, 8'ha5, 8'h00, i[2:0]);
    end
  endtask

  task automatic t_set_swap();
    set_state(8'h99, 4'h5);
    run_op(SET_BYTE, 8'h12, 8'h00, 3'h0);
    for (int i = 0; i < 8; i++) begin
      run_op(SET_BIT, 8'h10, 8'h00, i[2:0]);
    end
    run_op(NIBBLE_EXCHANGE_MEM, 8'h3c, 8'h00, 3'h0);
    run_op(NIBBLE_EXCHANGE_ACC, 8'hd2, 8'h00, 3'h0);
  endtask

  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard: the whole run needs about 524 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    {op_valid, op_code, op_addr, op_bit, op_imm} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    @(posedge ref_clk);
    t_apb();
    t_rotate();
    t_sub();
    t_skip();
    t_set_swap();
    end_of_test();
  end
endmodule

`default_nettype wire
